// ---- shared/ssw_defs.svh ----
// Timing constants of the supply supervisor and watchdog
`ifndef SSW_DEFS_SVH
`define SSW_DEFS_SVH

// ----------------------------------------
// Clock rate
// ----------------------------------------
`define SSW_CLK_MHZ          250

// ----------------------------------------
// Times in their own units
// ----------------------------------------
`define SSW_FAULT_PULSE_MS   200
`define SSW_KICK_TIMEOUT_MS  1600
`define SSW_STARTUP_MS       2000
`define SSW_RESET_HOLD_MS    200
`define SSW_PWRUP_EXTRA_MS   4
`define SSW_SETTLE_US        300
`define SSW_KICK_MIN_NS      1000
`define SSW_MRD_NS           250
`define SSW_EN_GLITCH_NS     300
`define SSW_MR_GLITCH_NS     200

// ----------------------------------------
// Cycle counts (least times round up)
// ----------------------------------------
`define SSW_MS_CYC(t)        ((t) * `SSW_CLK_MHZ * 1000)
`define SSW_US_CYC(t)        ((t) * `SSW_CLK_MHZ)
`define SSW_NS_CYC(t)        (((t) * `SSW_CLK_MHZ + 999) / 1000)
`define SSW_FAULT_PULSE_CYC  `SSW_MS_CYC(`SSW_FAULT_PULSE_MS)
`define SSW_KICK_TIMEOUT_CYC `SSW_MS_CYC(`SSW_KICK_TIMEOUT_MS)
`define SSW_STARTUP_CYC      `SSW_MS_CYC(`SSW_STARTUP_MS)
`define SSW_RESET_HOLD_CYC   `SSW_MS_CYC(`SSW_RESET_HOLD_MS)
`define SSW_PWRUP_EXTRA_CYC  `SSW_MS_CYC(`SSW_PWRUP_EXTRA_MS)
`define SSW_SETTLE_CYC       `SSW_US_CYC(`SSW_SETTLE_US)
`define SSW_KICK_MIN_CYC     `SSW_NS_CYC(`SSW_KICK_MIN_NS)
`define SSW_MRD_CYC          `SSW_NS_CYC(`SSW_MRD_NS)
`define SSW_EN_GLITCH_CYC    `SSW_NS_CYC(`SSW_EN_GLITCH_NS)
`define SSW_MR_GLITCH_CYC    `SSW_NS_CYC(`SSW_MR_GLITCH_NS)
`define SSW_MR_FILT_CYC      (`SSW_MRD_CYC - 1)

`endif

// ---- shared/ssw_pkg.sv ----
// Types of the supply supervisor and watchdog
package ssw_pkg;

	// ----------------------------------------
	// Supervisor reset states
	// ----------------------------------------
	typedef enum logic [2:0] {
		RS_ASSERT = 3'b001,
		RS_HOLD   = 3'b010,
		RS_RUN    = 3'b100
	} ssw_rs_e;

	// ----------------------------------------
	// Watchdog states
	// ----------------------------------------
	typedef enum logic [4:0] {
		WD_START  = 5'b00001,
		WD_IDLE   = 5'b00010,
		WD_SETTLE = 5'b00100,
		WD_MON    = 5'b01000,
		WD_FAULT  = 5'b10000
	} ssw_wd_e;

	// Filtered control inputs
	typedef struct packed {
		logic enable;
		logic mr_n;
	} ssw_flt_s;

endpackage

// ---- hw/ssw_filter.sv ----
// Glitch filter for a slow control input
`timescale 1ns/1ps

module ssw_filter
	import ssw_pkg::*;
#(
	parameter int   FILT_CYC = 50,
	parameter logic INIT     = 1'b1
)(
	input  wire logic i_core_clk,
	input  wire logic i_nrst,
	input  wire logic i_ce,
	input  wire logic i_level,
	output logic      o_level
);

	localparam int CW = $clog2(FILT_CYC + 1);
	localparam logic [CW-1:0] LAST = CW'(FILT_CYC - 1);

	generate
		if (FILT_CYC < 1)
		begin : g_chk
			$error("Filter length must be at least one cycle");
		end
	endgenerate

	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	logic          lvl_q;
	logic          lvl_d;

	// ----------------------------------------
	// Level moves only after a full stable run
	// ----------------------------------------
	always_comb
	begin
		cnt_d = cnt_q;
		lvl_d = lvl_q;
		if (i_level == lvl_q)
		begin
			cnt_d = '0;
		end
		else if (cnt_q == LAST)
		begin
			cnt_d = '0;
			lvl_d = i_level;
		end
		else
		begin
			cnt_d = cnt_q + CW'(1);
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			cnt_q <= '0;
			lvl_q <= INIT;
		end
		else if (i_ce)
		begin
			cnt_q <= cnt_d;
			lvl_q <= lvl_d;
		end
	end

	assign o_level = lvl_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	filt_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst) // RULE_16
		i_ce && (i_level == lvl_q) |=> $stable(lvl_q))
		else $error("Filter output moved while input agreed");

endmodule

// ---- hw/ssw_top.sv ----
// Supply supervisor reset and watchdog timer
// Overview of operation
// RULE_01: Kick steady high or low for whole timeout yields one fault pulse.
// RULE_02: Watchdog counter restarts on reset deassertion and on each kick falling edge.
// RULE_03: Fault output stays low one fault pulse width, then releases.
// RULE_04: Enable high runs watchdog; enable low stops it and ignores kicks.
// RULE_05: After enable rises, wait the settle time before monitoring kicks.
// RULE_06: Host keeps each kick pulse at least one microsecond wide.
// RULE_07: Reset output stays asserted while manual reset input is low.
// RULE_08: After manual reset releases, reset holds for full hold time.
// RULE_09: Reset asserts about 250 ns after manual reset goes low.
// RULE_10: Reset asserts under trip level; holds hold time after supply recovers.
// RULE_11: Fast supply rise at power-up adds about 4 ms of hold.
// RULE_12: Unconnected manual reset input reads as inactive high.
// RULE_13: Kicks ignored during fault, reset and startup delay.
// RULE_14: Startup delay starts at reset deassertion; monitoring follows it.
// RULE_15: Timing measured from last falling edge of a wide enough kick pulse.
// RULE_16: Enable and manual reset inputs are glitch filtered.
// RULE_17: Timeout, startup delay and hold are build-time parameters.
`timescale 1ns/1ps
`include "ssw_defs.svh"

module ssw_top
	import ssw_pkg::*;
#(
	parameter int CNT_W            = 32,
	parameter int KW               = 16,
	parameter int KICK_TIMEOUT_CYC = `SSW_KICK_TIMEOUT_CYC,
	parameter int FAULT_PULSE_CYC  = `SSW_FAULT_PULSE_CYC,
	parameter int STARTUP_CYC      = `SSW_STARTUP_CYC,
	parameter int RESET_HOLD_CYC   = `SSW_RESET_HOLD_CYC,
	parameter int PWRUP_EXTRA_CYC  = `SSW_PWRUP_EXTRA_CYC,
	parameter int SETTLE_CYC       = `SSW_SETTLE_CYC
)(
	input  wire logic i_core_clk,
	input  wire logic i_nrst,
	input  wire logic i_ce,
	input  wire logic i_supply_ok,
	input  wire logic i_supply_fast_rise,
	input  wire logic i_manual_reset_n,
	input  wire logic i_manual_reset_float,
	input  wire logic i_watchdog_enable_in,
	input  wire logic i_watchdog_kick_in,
	output logic      o_supervisor_reset_n,
	output logic      o_watchdog_fault_n
);

	localparam logic [CNT_W-1:0] TO_M1     = CNT_W'(KICK_TIMEOUT_CYC - 1);
	localparam logic [CNT_W-1:0] FAULT_M1  = CNT_W'(FAULT_PULSE_CYC - 1);
	localparam logic [CNT_W-1:0] START_M1  = CNT_W'(STARTUP_CYC - 1);
	localparam logic [CNT_W-1:0] HOLD_M1   = CNT_W'(RESET_HOLD_CYC - 1);
	localparam logic [CNT_W-1:0] EXTRA     = CNT_W'(PWRUP_EXTRA_CYC);
	localparam logic [CNT_W-1:0] SETTLE_M1 = CNT_W'(SETTLE_CYC - 1);
	localparam logic [KW-1:0]    KICK_MIN  = KW'(`SSW_KICK_MIN_CYC);

	generate
		if (KICK_TIMEOUT_CYC < 2 || FAULT_PULSE_CYC < 1 || STARTUP_CYC < 1 || RESET_HOLD_CYC < 1
			|| SETTLE_CYC < 1 || `SSW_KICK_MIN_CYC >= (2 ** KW) || `SSW_MR_FILT_CYC < `SSW_MR_GLITCH_CYC)
		begin : g_chk
			$error("Unsupported timing parameters");
		end
	endgenerate

	// ----------------------------------------
	// Input filtering
	// ----------------------------------------
	ssw_flt_s flt;
	logic     mr_pin;

	assign mr_pin = i_manual_reset_n | i_manual_reset_float; // RULE_12

	// Longer than the glitch window, so it also sets the manual reset delay
	ssw_filter #(.FILT_CYC(`SSW_MR_FILT_CYC), .INIT(1'b1)) u_mr_filt ( // RULE_09 RULE_16
		.i_core_clk (i_core_clk),
		.i_nrst     (i_nrst),
		.i_ce       (i_ce),
		.i_level    (mr_pin),
		.o_level    (flt.mr_n)
	);

	ssw_filter #(.FILT_CYC(`SSW_EN_GLITCH_CYC), .INIT(1'b0)) u_en_filt ( // RULE_16
		.i_core_clk (i_core_clk),
		.i_nrst     (i_nrst),
		.i_ce       (i_ce),
		.i_level    (i_watchdog_enable_in),
		.o_level    (flt.enable)
	);

	function automatic logic is_watching(input ssw_wd_e s);
		is_watching = (s == WD_MON);
	endfunction

	// ----------------------------------------
	// Supervisor reset
	// ----------------------------------------
	ssw_rs_e          rs_q;
	ssw_rs_e          rs_d;
	logic [CNT_W-1:0] rcnt_q;
	logic [CNT_W-1:0] rcnt_d;
	logic             first_q;
	logic             first_d;
	logic             cap_q;
	logic             cap_d;
	logic             fast_q;
	logic             fast_d;
	logic             rst_n_q;
	logic             cause;
	logic [CNT_W-1:0] hold_tgt;

	assign cause = !i_supply_ok || !flt.mr_n; // RULE_07 RULE_10

	always_comb
	begin
		rs_d     = rs_q;
		rcnt_d   = rcnt_q;
		first_d  = first_q;
		cap_d    = 1'b0;
		fast_d   = cap_q ? i_supply_fast_rise : fast_q;
		hold_tgt = (first_q && fast_q) ? HOLD_M1 + EXTRA : HOLD_M1; // RULE_11
		if (cause)
		begin
			rs_d   = RS_ASSERT;
			rcnt_d = '0;
		end
		else
		begin
			case (rs_q)
				RS_ASSERT:
				begin
					rs_d   = RS_HOLD;
					rcnt_d = '0;
				end
				RS_HOLD:
				begin
					if (rcnt_q == hold_tgt) // RULE_08 RULE_10 RULE_17
					begin
						rs_d    = RS_RUN;
						first_d = 1'b0;
					end
					else
					begin
						rcnt_d = rcnt_q + CNT_W'(1);
					end
				end
				default:
				begin
					rs_d = RS_RUN;
				end
			endcase
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			rs_q    <= RS_ASSERT;
			rcnt_q  <= '0;
			first_q <= 1'b1;
			cap_q   <= 1'b1;
			fast_q  <= 1'b0;
			rst_n_q <= 1'b0;
		end
		else if (i_ce)
		begin
			rs_q    <= rs_d;
			rcnt_q  <= rcnt_d;
			first_q <= first_d;
			cap_q   <= cap_d;
			fast_q  <= fast_d;
			rst_n_q <= (rs_d == RS_RUN);
		end
	end

	// ----------------------------------------
	// Kick edge qualification
	// ----------------------------------------
	logic          kick_prev_q;
	logic [KW-1:0] kick_hi_q;
	logic [KW-1:0] kick_hi_d;
	logic          kick_valid;

	always_comb
	begin
		kick_hi_d  = kick_hi_q;
		kick_valid = kick_prev_q && !i_watchdog_kick_in && (kick_hi_q >= KICK_MIN); // RULE_06 RULE_15
		if (!i_watchdog_kick_in)
		begin
			kick_hi_d = '0;
		end
		else if (kick_hi_q != {KW{1'b1}})
		begin
			kick_hi_d = kick_hi_q + KW'(1);
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			kick_prev_q <= 1'b0;
			kick_hi_q   <= '0;
		end
		else if (i_ce)
		begin
			kick_prev_q <= i_watchdog_kick_in;
			kick_hi_q   <= kick_hi_d;
		end
	end

	// ----------------------------------------
	// Watchdog
	// ----------------------------------------
	ssw_wd_e          wd_q;
	ssw_wd_e          wd_d;
	logic [CNT_W-1:0] wcnt_q;
	logic [CNT_W-1:0] wcnt_d;
	logic             fault_n_q;

	always_comb
	begin
		wd_d   = wd_q;
		wcnt_d = wcnt_q;
		if (rs_q != RS_RUN)
		begin
			// Held cleared so the count starts fresh at deassertion
			wd_d   = WD_START; // RULE_02 RULE_13 RULE_14
			wcnt_d = '0;
		end
		else
		begin
			case (wd_q)
				WD_START:
				begin
					if (wcnt_q == START_M1) // RULE_14 RULE_17
					begin
						wcnt_d = '0;
						wd_d   = flt.enable ? WD_MON : WD_IDLE;
					end
					else
					begin
						wcnt_d = wcnt_q + CNT_W'(1);
					end
				end
				WD_IDLE:
				begin
					wcnt_d = '0;
					if (flt.enable)
					begin
						wd_d = WD_SETTLE;
					end
				end
				WD_SETTLE:
				begin
					if (!flt.enable)
					begin
						wd_d   = WD_IDLE;
						wcnt_d = '0;
					end
					else if (wcnt_q == SETTLE_M1) // RULE_05
					begin
						wd_d   = WD_MON;
						wcnt_d = '0;
					end
					else
					begin
						wcnt_d = wcnt_q + CNT_W'(1);
					end
				end
				WD_MON:
				begin
					if (!flt.enable) // RULE_04
					begin
						wd_d   = WD_IDLE;
						wcnt_d = '0;
					end
					else if (kick_valid) // RULE_02 RULE_15
					begin
						wcnt_d = '0;
					end
					else if (wcnt_q == TO_M1) // RULE_01 RULE_17
					begin
						wd_d   = WD_FAULT;
						wcnt_d = '0;
					end
					else
					begin
						wcnt_d = wcnt_q + CNT_W'(1);
					end
				end
				default:
				begin
					// Kicks during the pulse have no effect
					if (wcnt_q == FAULT_M1) // RULE_03 RULE_13
					begin
						wd_d   = flt.enable ? WD_MON : WD_IDLE;
						wcnt_d = '0;
					end
					else
					begin
						wcnt_d = wcnt_q + CNT_W'(1);
					end
				end
			endcase
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			wd_q      <= WD_START;
			wcnt_q    <= '0;
			fault_n_q <= 1'b1;
		end
		else if (i_ce)
		begin
			wd_q      <= wd_d;
			wcnt_q    <= wcnt_d;
			fault_n_q <= (wd_d != WD_FAULT);
		end
	end

	assign o_supervisor_reset_n = rst_n_q;
	assign o_watchdog_fault_n   = fault_n_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	logic [CNT_W-1:0] fault_len_q;
	logic [CNT_W-1:0] hold_len_q;

	always_ff @(posedge i_core_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			fault_len_q <= '0;
			hold_len_q  <= '0;
		end
		else if (i_ce)
		begin
			fault_len_q <= fault_n_q ? '0 : fault_len_q + CNT_W'(1);
			hold_len_q  <= (rs_q == RS_HOLD) ? hold_len_q + CNT_W'(1) : '0;
		end
	end

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_nrst);

	sequence s_expire;
		i_ce && is_watching(wd_q) && flt.enable && !kick_valid && (wcnt_q == TO_M1);
	endsequence

	sequence s_kick;
		i_ce && is_watching(wd_q) && flt.enable && kick_valid && (rs_q == RS_RUN);
	endsequence

	fault_start_a: assert property (s_expire ##0 (rs_q == RS_RUN) |=> !o_watchdog_fault_n) // RULE_01
		else $error("No fault pulse after timeout");
	kick_restart_a: assert property (s_kick |=> (wcnt_q == '0) && o_watchdog_fault_n) // RULE_02
		else $error("Valid kick did not restart counter");
	fault_width_a: assert property ($rose(o_watchdog_fault_n) && (rs_q == RS_RUN) // RULE_03
		|-> fault_len_q == CNT_W'(FAULT_PULSE_CYC))
		else $error("Fault pulse width wrong");
	enable_off_a: assert property (i_ce && !flt.enable && (rs_q == RS_RUN) && (wd_q != WD_FAULT) // RULE_04
		|=> !is_watching(wd_q))
		else $error("Watchdog ran with enable low");
	settle_len_a: assert property (is_watching(wd_q) && $past(wd_q) == WD_SETTLE // RULE_05
		|-> $past(wcnt_q) == SETTLE_M1)
		else $error("Settle time too short");
	mr_hold_a: assert property (i_ce && !flt.mr_n |=> !o_supervisor_reset_n) // RULE_07
		else $error("Reset released during manual reset");
	hold_time_a: assert property ($rose(o_supervisor_reset_n) |-> hold_len_q >= CNT_W'(RESET_HOLD_CYC)) // RULE_08
		else $error("Reset hold too short");
	supply_low_a: assert property (i_ce && !i_supply_ok |=> !o_supervisor_reset_n ##0 (rs_q == RS_ASSERT)) // RULE_10
		else $error("Reset not asserted under trip level");
	fault_ignore_a: assert property (i_ce && (wd_q == WD_FAULT) && (rs_q == RS_RUN) && (wcnt_q != FAULT_M1) // RULE_13
		|=> (wd_q == WD_FAULT) && (wcnt_q == $past(wcnt_q) + CNT_W'(1)))
		else $error("Kick disturbed fault pulse");
	startup_a: assert property ($rose(o_supervisor_reset_n) |-> (wd_q == WD_START) && (wcnt_q == '0)) // RULE_14
		else $error("Startup delay not begun at reset release");

endmodule

// ---- verification/ssw_host_model.sv ----
// Behavioural host that toggles the watchdog kick line
`timescale 1ns/1ps

module ssw_host_model
#(
	parameter int HIGH_CYC  = 260,
	parameter int LOW_CYC   = 260,
	parameter int SHORT_CYC = 100,
	parameter int SLOW_CYC  = 600
)(
	input  wire logic i_core_clk,
	input  wire logic i_reset_n,
	input  wire logic i_run,
	input  wire logic i_short,
	input  wire logic i_slow,
	input  wire logic i_idle_level,
	output logic      o_kick
);
	// ----------------------------------------
	// Kick generator
	// ----------------------------------------
	int cnt_q;

	initial
	begin
		o_kick = 1'b0;
		cnt_q  = 0;
	end

	// Held host leaves the line to the board pull
	always @(posedge i_core_clk)
	begin
		#1;
		if (!i_run || !i_reset_n)
		begin
			o_kick <= i_idle_level;
			cnt_q  <= 0;
		end
		else if (cnt_q > 0)
			cnt_q <= cnt_q - 1;
		else
		begin
			o_kick <= !o_kick;
			// Short high phase only when a scenario asks for it
			if (!o_kick)
				cnt_q <= (i_short ? SHORT_CYC : HIGH_CYC) - 1;
			else
				cnt_q <= (i_slow ? SLOW_CYC : LOW_CYC) - 1;
		end
	end
endmodule

// ---- verification/ssw_top_tb.sv ----
// Self-checking bench of the supervisor and watchdog
`timescale 1ns/1ps

module ssw_top_tb;
	// ----------------------------------------
	// Short sim counts
	// ----------------------------------------
	localparam int TO  = 600;
	localparam int FP  = 50;
	localparam int SU  = 100;
	localparam int RH  = 40;
	localparam int PX  = 20;
	localparam int ST  = 30;
	localparam int MRF = 62;
	localparam int ENF = 75;
	localparam bit RS  = 1'b0;
	localparam bit FL  = 1'b1;

	logic clk, nrst, supply_ok, fast_rise, mr_n, mr_float, watchdog_enable_in;
	logic h_run, h_short, h_slow, h_idle, kick, rst_n, fault_n, ce;
	int   error_cnt = 0;
	int   checked   = 0;
	int   n;

	initial clk = 1'b0;
	always #2 clk = ~clk;

	ssw_top #(.KICK_TIMEOUT_CYC(TO), .FAULT_PULSE_CYC(FP), .STARTUP_CYC(SU),
		.RESET_HOLD_CYC(RH), .PWRUP_EXTRA_CYC(PX), .SETTLE_CYC(ST)) i_ssw_top
	(
		.i_core_clk           (clk),
		.i_nrst               (nrst),
		.i_ce                 (ce),
		.i_supply_ok          (supply_ok),
		.i_supply_fast_rise   (fast_rise),
		.i_manual_reset_n     (mr_n),
		.i_manual_reset_float (mr_float),
		.i_watchdog_enable_in (watchdog_enable_in),
		.i_watchdog_kick_in   (kick),
		.o_supervisor_reset_n (rst_n),
		.o_watchdog_fault_n   (fault_n)
	);

	ssw_host_model i_ssw_host_model
	(
		.i_core_clk   (clk),
		.i_reset_n    (rst_n),
		.i_run        (h_run),
		.i_short      (h_short),
		.i_slow       (h_slow),
		.i_idle_level (h_idle),
		.o_kick       (kick)
	);

	// ----------------------------------------
	// Shared helpers
	// ----------------------------------------
	task automatic complete_run();
		$display("errors %0d checks %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input bit ok, input string msg);
		checked++;
		if (!ok)
		begin
			error_cnt++;
			$display("[ERR] %0t %s", $time, msg);
		end
	endtask

	function automatic logic sel(input bit w);
		return w ? fault_n : rst_n;
	endfunction

	// Waits are bounded; running out ends the run
	task automatic wait_for(input bit w, input logic v, input int maxc, output int cnt);
		cnt = 0;
		while (cnt < maxc)
		begin
			@(posedge clk);
			#1;
			cnt++;
			if (sel(w) === v)
				return;
		end
		chk(1'b0, "wait ran out");
		complete_run();
	endtask

	task automatic hold_chk(input bit w, input logic v, input int ncyc);
		for (int i = 0; i < ncyc; i++)
		begin
			@(posedge clk);
			#1;
			if (sel(w) !== v)
			begin
				chk(1'b0, "output left its level early");
				return;
			end
		end
		chk(1'b1, "");
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic power_up();
		wait_for(RS, 1'b1, 200, n);
		chk(n >= 1 + RH + PX && n <= 2 + RH + PX, "first hold length");
	endtask

	task automatic steady_kick();
		hold_chk(FL, 1'b1, SU + TO - 20);
		wait_for(FL, 1'b0, 40, n);
		wait_for(FL, 1'b1, FP + 10, n);
		chk(n == FP, "fault pulse width");
		h_idle = 1'b1;
		hold_chk(FL, 1'b1, TO - 10);
		wait_for(FL, 1'b0, 20, n);
	endtask

	task automatic good_kicks();
		// Clock enable low freezes the pulse at its start
		ce = 1'b0;
		hold_chk(FL, 1'b0, 100);
		chk(rst_n === 1'b1, "reset moved while frozen");
		ce = 1'b1;
		wait_for(FL, 1'b1, FP + 10, n);
		chk(n == FP, "frozen pulse width");
		h_run = 1'b1;
		hold_chk(FL, 1'b1, 3 * TO);
	endtask

	task automatic bad_kicks();
		h_short = 1'b1;
		wait_for(FL, 1'b0, 2 * TO, n);
		wait_for(FL, 1'b1, FP + 10, n);
		h_short = 1'b0;
		h_slow = 1'b1;
		wait_for(FL, 1'b0, 2 * TO, n);
		wait_for(FL, 1'b1, FP + 10, n);
		h_slow = 1'b0;
	endtask

	task automatic enable_gate();
		h_run = 1'b0;
		watchdog_enable_in = 1'b0;
		hold_chk(FL, 1'b1, 2 * TO);
		watchdog_enable_in = 1'b1;
		hold_chk(FL, 1'b1, ENF + ST + TO - 15);
		wait_for(FL, 1'b0, 30, n);
		wait_for(FL, 1'b1, FP + 10, n);
	endtask

	task automatic manual_reset();
		mr_n = 1'b0;
		hold_chk(RS, 1'b1, 40);
		mr_n = 1'b1;
		hold_chk(RS, 1'b1, 80);
		mr_float = 1'b1;
		mr_n = 1'b0;
		hold_chk(RS, 1'b1, 100);
		mr_float = 1'b0;
		wait_for(RS, 1'b0, 80, n);
		chk(n >= MRF + 1 && n <= MRF + 2, "manual reset delay");
		hold_chk(RS, 1'b0, 100);
		mr_n = 1'b1;
		hold_chk(RS, 1'b0, MRF + RH - 5);
		wait_for(RS, 1'b1, 20, n);
	endtask

	task automatic supply_drop();
		supply_ok = 1'b0;
		wait_for(RS, 1'b0, 3, n);
		chk(n == 1, "supply low response");
		hold_chk(RS, 1'b0, 50);
		supply_ok = 1'b1;
		wait_for(RS, 1'b1, RH + 10, n);
		chk(n >= RH + 1 && n <= RH + 2, "later hold has no extra");
		hold_chk(FL, 1'b1, SU + TO - 20);
		wait_for(FL, 1'b0, 40, n);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		nrst = 1'b0;
		ce = 1'b1;
		supply_ok = 1'b1;
		fast_rise = 1'b1;
		mr_n = 1'b1;
		mr_float = 1'b0;
		watchdog_enable_in = 1'b1;
		h_run = 1'b0;
		h_short = 1'b0;
		h_slow = 1'b0;
		h_idle = 1'b0;
		repeat (3) @(posedge clk);
		#1;
		chk(rst_n === 1'b0 && fault_n === 1'b1, "outputs during reset");
		nrst = 1'b1;
		power_up();
		steady_kick();
		good_kicks();
		bad_kicks();
		enable_gate();
		manual_reset();
		supply_drop();
		complete_run();
	end
endmodule
